// ==== logic/pgt_buf2.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides sit on aclk; outputs come straight from flip-flops.
 */
`timescale 1ns/1ps
module pgt_buf2 #(
    parameter int WIDTH = 14
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // ==================================================================
    // Storage: slot 0 feeds the output, slot 1 catches a stalled word
    logic [WIDTH-1:0] slot1_q;
    logic full1_q;
    logic take;
    logic give;

    if (WIDTH < 1) begin : g_width_bad
        $error("pgt_buf2: WIDTH must be positive");
    end

    assign in_ready = !full1_q;
    assign take = in_valid && !full1_q;
    assign give = out_valid && out_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (!out_valid || give) begin
            if (full1_q) begin
                out_valid <= 1'b1;
                out_data <= slot1_q;
            end else begin
                out_valid <= take;
                if (take) out_data <= in_data;
            end
        end
    end

    // Second slot fills only while the output is stalled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full1_q <= 1'b0;
            slot1_q <= '0;
        end else if (full1_q) begin
            if (!out_valid || give) full1_q <= 1'b0;
        end else if (take && out_valid && !out_ready) begin
            full1_q <= 1'b1;
            slot1_q <= in_data;
        end
    end

endmodule // pgt_buf2

// ==== logic/pgt_pkg.sv ====
/*
 * Shared constants and types of the pixel gamma and test pattern stage.
 * Assumes a 40 MHz register clock and an AXI4-Lite register bus, 32 bits.
 */
package pgt_pkg;

    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GAMMA_RAW = 8'h04;
    localparam logic [7:0] REG_GAMMA_ABS = 8'h08;
    localparam logic [7:0] REG_LINE_LEN = 8'h0c;
    localparam logic [7:0] REG_FREE_PERIOD = 8'h10;
    localparam logic [7:0] REG_EXPOSURE = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // ==================================================================
    // Register field bit positions
    localparam int CTRL_LUT_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_PAT_LO = 4;
    localparam int CTRL_FREE_RUN = 8;
    localparam int STAT_BUSY = 16;
    localparam int ABS_SHIFT = 6;

    // ==================================================================
    // Reset values
    localparam logic [11:0] GAMMA_ONE = 12'h400;
    localparam logic [12:0] LINE_LEN_RST = 13'h1000;
    localparam logic [23:0] EXPOSURE_RST = 24'h000100;

    // ==================================================================
    // Timing: default free-run line period
    localparam int CLK_PERIOD_PS = 25000;
    localparam int FREE_PERIOD_NS = 10000;
    localparam int FREE_PERIOD_CYC = FREE_PERIOD_NS * 1000 / CLK_PERIOD_PS;

    // ==================================================================
    // Output modes, patterns and their levels
    typedef enum logic [1:0] {
        MODE_8 = 2'h0,
        MODE_10 = 2'h1,
        MODE_12 = 2'h2
    } pgt_mode_t;

    localparam logic [2:0] PAT_SENSOR = 3'h0;
    localparam logic [2:0] PAT_FIXED = 3'h1;
    localparam logic [2:0] PAT_MOVING = 3'h2;
    localparam logic [2:0] PAT_BLACK = 3'h3;
    localparam logic [2:0] PAT_GRAY = 3'h4;

    localparam logic [11:0] YMAX_8 = 12'h0ff;
    localparam logic [11:0] YMAX_10 = 12'h3fc;
    localparam logic [11:0] YMAX_12 = 12'hff0;
    localparam logic [11:0] GRAY_8 = 12'h07f;
    localparam logic [11:0] GRAY_10 = 12'h1ff;
    localparam logic [11:0] GRAY_12 = 12'h7ff;
    localparam logic [8:0] FIXED_PERIOD_MASK = 9'h1ff;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==================================================================
    // One output pixel with its line framing
    typedef struct packed {
        logic [11:0] value;
        logic first;
        logic last;
    } pgt_pixel_t;

endpackage

// ==== logic/pgt_top.sv ====
/*
 * Pixel output stage: gamma correction, four test patterns, line pacing,
 * AXI4-Lite register slave and a two-entry output buffer.
 * Assumes sensor pixels arrive on aclk as a valid/ready stream and the
 * line trigger pin is asynchronous to aclk.
 */
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Contract
// - Corrected value is (in / max) to the power gamma, times max.
// - Max brightness is 255, 1020 or 4080 for 8, 10, 12 bit output.
// - Gamma of exactly one passes every pixel unchanged.
// - Gamma below one brightens output; gamma above one darkens it.
// - Black and the mode's white pass unchanged for any gamma.
// - Correction acts only with lookup table enabled; software enables it first.
// - Gamma ranges 0 to 3.99902; nonzero gamma means correction is on; code also needs the lookup table enabled.
// - Gamma accepted as absolute or raw value in its register.
// - Test mode synthesises pixels without the sensor; four patterns.
// - Trigger mode emits exactly one line per external trigger cycle; code drops a trigger that arrives during a line.
// - Free run emits one line per internal line signal cycle; code drops a divider tick that arrives during a line.
// - Exposure setting never changes test pattern content or timing.
// - Pattern one: odd pixels count up, even count down, period 512.
// - Pattern one spans 0..1023 in 10 bit, 0..4095 in 12 bit.
// - Pattern two ramps 0..255 per 256 pixels, start advances per line.
// - Pattern three is zero for every pixel in every mode.
// - Pattern four is 127, 511 or 2047 for 8, 10, 12 bit.
module pgt_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_line_trigger,
    input wire logic [11:0] sensor_pixel,
    input wire logic sensor_valid,
    output logic sensor_ready,
    output pgt_pkg::pgt_pixel_t pix_data,
    output logic pix_valid,
    input wire logic pix_ready
);
    import pgt_pkg::*;

    // ==================================================================
    // Configuration registers
    logic lut_en_q;
    logic [1:0] mode_q;
    logic [2:0] pattern_q;
    logic free_run_q;
    logic [11:0] gamma_q;
    logic [12:0] line_len_q;
    logic [23:0] free_period_q;
    logic [23:0] exposure_q;
    logic [15:0] line_count_q;

    // ==================================================================
    // AXI4-Lite write path: address and data taken in either order
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_hit;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_comb begin
        case (aw_addr_q)
            REG_CTRL, REG_GAMMA_RAW, REG_GAMMA_ABS, REG_LINE_LEN,
            REG_FREE_PERIOD, REG_EXPOSURE, REG_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Registers update a whole word when its low byte lane is enabled;
    // byte-wise merging buys nothing for fields this narrow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lut_en_q <= 1'b0;
            mode_q <= MODE_8;
            pattern_q <= PAT_SENSOR;
            free_run_q <= 1'b0;
            gamma_q <= GAMMA_ONE;
            line_len_q <= LINE_LEN_RST;
            free_period_q <= 24'(FREE_PERIOD_CYC);
            exposure_q <= EXPOSURE_RST;
        end else if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q)
                REG_CTRL: begin
                    lut_en_q <= w_data_q[CTRL_LUT_EN];
                    mode_q <= w_data_q[CTRL_MODE_LO +: 2];
                    pattern_q <= w_data_q[CTRL_PAT_LO +: 3];
                    free_run_q <= w_data_q[CTRL_FREE_RUN];
                end
                REG_GAMMA_RAW: gamma_q <= w_data_q[11:0];
                REG_GAMMA_ABS: begin
                    // Absolute value in 16.16, saturated to the top step
                    if (|w_data_q[31:18]) gamma_q <= 12'hfff;
                    else gamma_q <= w_data_q[17:6];
                end
                REG_LINE_LEN: if (|w_data_q[12:0]) begin
                    line_len_q <= w_data_q[12:0];
                end
                REG_FREE_PERIOD: if (|w_data_q[23:0]) begin
                    free_period_q <= w_data_q[23:0];
                end
                REG_EXPOSURE: exposure_q <= w_data_q[23:0];
                default: ;
            endcase
        end
    end

    // ==================================================================
    // AXI4-Lite read path
    logic busy;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {23'h0, free_run_q, 1'b0,
                    pattern_q, 1'b0, mode_q, lut_en_q};
                REG_GAMMA_RAW: s_axi_rdata <= {20'h0, gamma_q};
                REG_GAMMA_ABS: s_axi_rdata <= {14'h0, gamma_q, 6'h0};
                REG_LINE_LEN: s_axi_rdata <= {19'h0, line_len_q};
                REG_FREE_PERIOD: s_axi_rdata <= {8'h0, free_period_q};
                REG_EXPOSURE: s_axi_rdata <= {8'h0, exposure_q};
                REG_STATUS: s_axi_rdata <= {15'h0, busy, line_count_q};
                default: s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==================================================================
    // Line pacing: synchronised trigger edge or free-run divider
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;
    logic [23:0] free_cnt_q;
    logic free_tick;
    logic line_start;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= external_line_trigger;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    // Exposure never feeds the divider, so patterns keep their pace
    always_ff @(posedge aclk) begin
        if (!aresetn || !free_run_q) begin
            free_cnt_q <= '0;
        end else if (free_cnt_q >= free_period_q - 24'h1) begin
            free_cnt_q <= '0;
        end else begin
            free_cnt_q <= free_cnt_q + 24'h1;
        end
    end

    assign free_tick = free_run_q && (free_cnt_q >= free_period_q - 24'h1);
    // A trigger edge during a line is dropped: no line without a trigger
    assign line_start = free_run_q ? free_tick
        : (trig_s2_q && !trig_s3_q);

    // ==================================================================
    // Line state machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LINE = 2'b10
    } pgt_state_t;

    pgt_state_t state_q;
    logic [12:0] idx_q;
    logic [7:0] offset_q;
    logic src_valid;
    logic src_take;
    logic buf_in_ready;
    logic test_mode;

    assign busy = (state_q == ST_LINE);
    assign test_mode = (pattern_q != PAT_SENSOR);
    assign src_valid = busy && (test_mode || sensor_valid);
    assign src_take = src_valid && buf_in_ready;
    assign sensor_ready = busy && !test_mode && buf_in_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
            line_count_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: if (line_start) begin
                    state_q <= ST_LINE;
                    idx_q <= '0;
                end
                ST_LINE: if (src_take) begin
                    idx_q <= idx_q + 13'h1;
                    if (idx_q == line_len_q - 13'h1) begin
                        state_q <= ST_IDLE;
                        line_count_q <= line_count_q + 16'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Moving gradient start advances once per accepted line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            offset_q <= '0;
        end else if (state_q == ST_IDLE && line_start) begin
            offset_q <= offset_q + 8'h1;
        end
    end

    // ==================================================================
    // Test pattern synthesis
    function automatic logic [11:0] scale8(input logic [7:0] v,
            input logic [1:0] m);
        case (m)
            MODE_8: scale8 = {4'h0, v};
            MODE_10: scale8 = {2'h0, v, v[7:6]};
            default: scale8 = {v, v[7:4]};
        endcase
    endfunction

    logic [8:0] fixed_pos;
    logic [7:0] fixed_v;
    logic [7:0] moving_v;
    logic [11:0] pat_value;

    // Pixel one is index zero, so odd pixels sit at even indices
    assign fixed_pos = idx_q[8:0] & FIXED_PERIOD_MASK;
    assign fixed_v = fixed_pos[0] ? 8'hff - fixed_pos[8:1]
        : fixed_pos[8:1];
    // Offset is already one during the first line, so subtract it back
    assign moving_v = idx_q[7:0] + offset_q - 8'h1;

    always_comb begin
        case (pattern_q)
            PAT_FIXED: pat_value = scale8(fixed_v, mode_q);
            PAT_MOVING: pat_value = scale8(moving_v, mode_q);
            PAT_BLACK: pat_value = 12'h0;
            PAT_GRAY: begin
                case (mode_q)
                    MODE_8: pat_value = GRAY_8;
                    MODE_10: pat_value = GRAY_10;
                    default: pat_value = GRAY_12;
                endcase
            end
            default: pat_value = 12'h0;
        endcase
    end

    // ==================================================================
    // Gamma correction: log2 and exp2 by leading-one approximation.
    // Trades exactness for a small single-cycle path; ends stay exact.
    logic [11:0] ymax;
    logic [2:0] norm_sh;
    logic [20:0] norm_prod;
    logic [15:0] frac;
    logic [3:0] lead;
    logic [15:0] aligned;
    logic [14:0] neg_log;
    logic [26:0] scaled_log;
    logic [16:0] exp_base;
    logic [16:0] exp_val;
    logic [28:0] out_prod;
    logic [11:0] gamma_out;
    logic gamma_on;

    always_comb begin
        case (mode_q)
            MODE_8: ymax = YMAX_8;
            MODE_10: ymax = YMAX_10;
            default: ymax = YMAX_12;
        endcase
        norm_sh = (mode_q == MODE_8) ? 3'h0 : (mode_q == MODE_10) ? 3'h2
            : 3'h4;
    end

    always_comb begin
        lead = '0;
        // Input over max brightness in 16-bit fraction: x*257 >> shift
        norm_prod = 21'(sensor_pixel) * 21'h101;
        frac = 16'(norm_prod >> norm_sh);
        for (int i = 0; i < 16; i++) begin
            if (frac[i]) lead = 4'(i);
        end
        aligned = frac << (4'hf - lead);
        neg_log = (15'(5'h10 - {1'b0, lead}) << 10) - 15'(aligned[14:5]);
        scaled_log = 27'(neg_log) * 27'(gamma_q);
        exp_base = 17'h10000 - {2'h0, scaled_log[19:10], 5'h0};
        if (scaled_log[26:20] > 7'h10) exp_val = '0;
        else exp_val = exp_base >> scaled_log[24:20];
        out_prod = 29'(exp_val) * 29'(ymax) + 29'h8000;
        if (sensor_pixel == 12'h0 || sensor_pixel >= ymax) begin
            gamma_out = sensor_pixel;
        end else if (gamma_q == GAMMA_ONE) begin
            gamma_out = sensor_pixel;
        end else begin
            // Larger gamma shrinks the fraction, so darker; smaller brightens
            gamma_out = out_prod[27:16];
        end
    end

    assign gamma_on = lut_en_q && (gamma_q != 12'h0);

    // ==================================================================
    // Output buffer: a receiver stall holds the line without loss
    pgt_pixel_t src_pix;

    always_comb begin
        src_pix.value = test_mode ? pat_value
            : (gamma_on ? gamma_out : sensor_pixel);
        src_pix.first = (idx_q == 13'h0);
        src_pix.last = (idx_q == line_len_q - 13'h1);
    end

    pgt_buf2 #(
        .WIDTH($bits(pgt_pixel_t))
    ) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(src_valid),
        .in_ready(buf_in_ready),
        .in_data(src_pix),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix_data)
    );

endmodule // pgt_top

// ==== testbench/pgt_grabber.sv ====
/* Frame grabber model at the pixel port of pgt_top.
   Assumes the bench asks for each trigger with a one cycle fire pulse. */
`timescale 1ns/1ps
module pgt_grabber (
    input wire logic aclk,
    input wire logic stall,
    input wire logic fire,
    output logic pix_ready,
    output logic external_line_trigger
);
    logic [1:0] ph_q = 2'h0;
    logic [2:0] hi_q = 3'h0;
    always_ff @(posedge aclk) begin
        ph_q <= ph_q + 2'h1;
        hi_q <= fire ? 3'h4 : (hi_q != 3'h0 ? hi_q - 3'h1 : 3'h0);
    end
    // Slow mode takes one pixel in four, so the buffer fills up
    assign pix_ready = !stall || ph_q == 2'h3;
    // Four cycles wide so the synchroniser cannot miss it
    assign external_line_trigger = hi_q != 3'h0;
endmodule // pgt_grabber

// ==== testbench/pgt_top_sva.sv ====
/* Port checker for pgt_top.
   Assumes the control word is written with address and data together. */
`timescale 1ns/1ps
module pgt_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sensor_ready,
    input wire pgt_pkg::pgt_pixel_t pix_data,
    input wire logic pix_valid,
    input wire logic pix_ready
);
    import pgt_pkg::*;
    logic [8:0] ctrl_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Shadow of the control word, to know which pattern runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 9'h0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                && s_axi_wready && s_axi_awaddr == REG_CTRL
                && s_axi_wstrb[0]) begin
            ctrl_q <= s_axi_wdata[8:0];
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ==========================================================
    // Properties
    a_wr_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write response repeated");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answer repeated");
    a_pix_hold: assert property (pix_valid && !pix_ready |=>
        pix_valid && $stable(pix_data)) else $error("pixel dropped");
    a_black_zero: assert property (pix_valid &&
        ctrl_q[6:4] == PAT_BLACK |-> pix_data.value == 12'h0)
        else $error("black pattern not zero");
    a_gray_level: assert property (pix_valid &&
        ctrl_q[6:4] == PAT_GRAY && ctrl_q[2:1] == MODE_8
        |-> pix_data.value == GRAY_8) else $error("gray level wrong");
    a_sensor_off: assert property (ctrl_q[6:4] != PAT_SENSOR
        |-> !sensor_ready) else $error("sensor used in test mode");
endmodule // pgt_top_sva

// ==== testbench/test_pgt_top.sv ====
/* Bench for pgt_top: registers, patterns, gamma and free run.
   Assumes pgt_grabber stands at the pixel port as frame grabber. */
`timescale 1ns/1ps
module test_pgt_top;
    import pgt_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, stall = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, sensor_valid = 1, fire = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, pix_ready;
    logic s_axi_rvalid, external_line_trigger, sensor_ready, pix_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] sensor_pixel = 12'h0, got[$];
    pgt_pixel_t pix_data;
    int n_mismatch = 0, checked = 0, lines = 0, cyc = 0, lst = 0, firsts[$];
    always #12.5 aclk = ~aclk;
    pgt_top i_pgt_top (.*);
    pgt_grabber i_pgt_grabber (.*);
    // ==========================================================
    // Pixel monitor and sensor source
    always @(posedge aclk) begin
        cyc++;
        if (pix_valid && pix_ready) got.push_back(pix_data.value);
        if (pix_valid && pix_ready && pix_data.first) firsts.push_back(cyc);
        if (pix_valid && pix_ready) lst <= pix_data.last;
        if (sensor_valid && sensor_ready) sensor_pixel <= sensor_pixel + 1;
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // Bus master; waits on the answer, the watchdog ends any hang
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
    endtask
    task automatic line(int len);
        got.delete();
        @(posedge aclk);
        sensor_pixel <= 12'h0;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        for (int i = 0; i < 30000 && got.size() < len; i++) @(posedge aclk);
        repeat (60) @(posedge aclk);
        chk("line length", got.size(), len);
        chk("last flag", lst, 1);
        lines++;
    endtask
    function automatic logic [11:0] ex(int pt, int md, int n, int l);
        logic [7:0] v;
        if (pt == 4) return md == 0 ? GRAY_8 : md == 1 ? GRAY_10 : GRAY_12;
        if (pt == 1) v = n % 2 == 0 ? 8'(n % 512 / 2) : 8'(255 - n % 512 / 2);
        else if (pt == 2) v = 8'((n + l) % 256);
        else v = 8'h0;
        return md == 0 ? {4'h0, v} : md == 1 ? {2'h0, v, v[7:6]} : {v, v[7:4]};
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd(REG_CTRL, 32'h0, RESP_OKAY);
        rd(REG_GAMMA_RAW, 32'(GAMMA_ONE), RESP_OKAY);
        rd(REG_LINE_LEN, 32'(LINE_LEN_RST), RESP_OKAY);
        rd(REG_EXPOSURE, 32'(EXPOSURE_RST), RESP_OKAY);
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h1, RESP_SLVERR);
        wr(REG_GAMMA_ABS, 32'h18000, RESP_OKAY);
        rd(REG_GAMMA_RAW, 32'h600, RESP_OKAY);
        wr(REG_GAMMA_ABS, 32'h50000, RESP_OKAY);
        rd(REG_GAMMA_ABS, 32'h3ffc0, RESP_OKAY);
        $display("t_regs done");
    endtask
    task automatic t_pat();
        wr(REG_LINE_LEN, 32'd520, RESP_OKAY);
        for (int md = 0; md < 3; md++) begin
            for (int pt = 1; pt < 5; pt++) begin
                stall <= md == 2;
                wr(REG_EXPOSURE, 32'hffffff >> pt, RESP_OKAY);
                wr(REG_CTRL, 32'(pt * 16 + md * 2), RESP_OKAY);
                line(520);
                for (int n = 0; n < 520; n++)
                    chk("pixel", got[n], ex(pt, md, n, lines - 1));
            end
        end
        rd(REG_STATUS, 32'd12, RESP_OKAY);
        stall <= 1'b0;
        $display("t_pat done");
    endtask
    task automatic t_gam();
        wr(REG_LINE_LEN, 32'd256, RESP_OKAY);
        for (int k = 0; k < 5; k++) begin
            wr(REG_CTRL, k == 1 ? 32'h0 : 32'h1, RESP_OKAY);
            wr(REG_GAMMA_RAW, k == 0 ? 32'h400 : k == 2 ? 32'h0 :
                k == 3 ? 32'h200 : 32'h800, RESP_OKAY);
            line(256);
            chk("black", got[0], 12'h0);
            chk("white", got[255], YMAX_8);
            for (int n = 32; n < 255; n += 32)
                chk("gamma", k < 3 ? got[n] == n : k == 3 ? got[n] > n :
                    got[n] < n, 1'b1);
        end
        $display("t_gam done");
    endtask
    task automatic t_free();
        wr(REG_LINE_LEN, 32'd16, RESP_OKAY);
        wr(REG_FREE_PERIOD, 32'd50, RESP_OKAY);
        firsts.delete();
        wr(REG_CTRL, 32'h140, RESP_OKAY);
        rd(REG_CTRL, 32'h140, RESP_OKAY);
        for (int i = 0; i < 2000 && firsts.size() < 4; i++) @(posedge aclk);
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        chk("period", firsts[2] - firsts[1], 50);
        chk("period", firsts[3] - firsts[2], 50);
        chk("gray", got[$], GRAY_8);
        $display("t_free done");
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pat();
        t_gam();
        t_free();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule // test_pgt_top
bind pgt_top pgt_top_sva i_pgt_top_sva (.*);
